/* rtl/erm_pkg.sv */
// Package with register map, field layout and access types of the expanded RAM mapper.
package erm_pkg;

	// ****************************************
	// Register offsets in the special function space
	// ****************************************
	localparam logic [7:0] ERM_PTR_LO_ADDR = 8'h82;
	localparam logic [7:0] ERM_PTR_HI_ADDR = 8'h83;
	localparam logic [7:0] ERM_PAGE_ADDR = 8'h85;
	localparam logic [7:0] ERM_BANK_ADDR = 8'h86;
	localparam logic [7:0] ERM_SYSCFG_ADDR = 8'hbf;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] ERM_PTR_LO_RST = 8'h00;
	localparam logic [7:0] ERM_PTR_HI_RST = 8'h00;
	localparam logic [7:0] ERM_PAGE_RST = 8'h00;
	localparam logic [7:0] ERM_BANK_RST = 8'h01;
	localparam logic [7:0] ERM_SYSCFG_RST = 8'h02;

	// ****************************************
	// Field positions and masks
	// ****************************************
	localparam int ERM_XRAM_EN_BIT = 1;
	localparam int ERM_BANK_EN_BIT = 7;
	localparam logic [7:0] ERM_PAGE_MASK = 8'h03;
	localparam logic [7:0] ERM_BANK_MASK = 8'h8f;
	localparam logic [7:0] ERM_SYSCFG_MASK = 8'h93;

	// ****************************************
	// Memory geometry
	// ****************************************
	localparam logic [15:0] ERM_XRAM_LAST = 16'h02ff;
	localparam logic [1:0] ERM_PAGE_OFFCHIP = 2'h3;
	localparam logic [7:0] ERM_WIN_LO = 8'h40;
	localparam logic [7:0] ERM_WIN_HI = 8'h7f;
	localparam logic [9:0] ERM_XRAM_BASE = 10'h100;

	// Target memory of one data access.
	typedef enum logic [1:0] {
		ERM_TGT_CORE,
		ERM_TGT_SCRATCH,
		ERM_TGT_XRAM,
		ERM_TGT_OFFCHIP
	} erm_target_e;

	// Kind of access presented by the core.
	typedef enum logic [1:0] {
		ERM_ACC_NONE,
		ERM_ACC_XMOVE_PTR,
		ERM_ACC_XMOVE_IDX,
		ERM_ACC_DIRECT
	} erm_access_e;

	// Access request from the core.
	typedef struct packed {
		erm_access_e kind;
		logic [7:0] indirect_index_reg;
		logic [7:0] direct_addr;
		logic [7:0] port2_upper_address;
	} erm_req_s;

	// Steered access towards the memories.
	typedef struct packed {
		erm_target_e target;
		logic [9:0] onchip_addr;
		logic [15:0] offchip_addr;
	} erm_route_s;

	// Special function register write and load port.
	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic ptr_load;
		logic [15:0] ptr_value;
	} erm_sfr_s;

endpackage

/* rtl/erm_decode.sv */
// Combinational address decoder that steers one access to its memory.
`timescale 1ns/1ps
module erm_decode
	import erm_pkg::*;
(
	// Request and configuration
	input wire erm_req_s req,
	input wire logic [15:0] data_pointer16,
	input wire logic onchip_xram_enable,
	input wire logic [1:0] xram_page_sel,
	input wire logic bank_window_enable,
	input wire logic [3:0] bank_window_select,
	// Result
	output erm_route_s route
);

	always_comb
	begin
		route.target = ERM_TGT_CORE;
		route.onchip_addr = 10'h000;
		route.offchip_addr = 16'h0000;
		unique case (req.kind)
			ERM_ACC_NONE:
			begin
				route.target = ERM_TGT_CORE;
			end
			ERM_ACC_XMOVE_PTR:
			begin
				route.offchip_addr = data_pointer16;
				if (onchip_xram_enable && data_pointer16 <= ERM_XRAM_LAST)
				begin
					route.target = ERM_TGT_XRAM;
					route.onchip_addr = data_pointer16[9:0];
				end
				else
				begin
					route.target = ERM_TGT_OFFCHIP;
				end
			end
			ERM_ACC_XMOVE_IDX:
			begin
				if (onchip_xram_enable && xram_page_sel != ERM_PAGE_OFFCHIP)
				begin
					route.target = ERM_TGT_XRAM;
					route.onchip_addr = {xram_page_sel, req.indirect_index_reg};
					route.offchip_addr = {6'h00, xram_page_sel, req.indirect_index_reg};
				end
				else
				begin
					route.target = ERM_TGT_OFFCHIP;
					route.offchip_addr = {req.port2_upper_address, req.indirect_index_reg};
				end
			end
			ERM_ACC_DIRECT:
			begin
				route.onchip_addr = {2'h0, req.direct_addr};
				route.target = ERM_TGT_CORE;
				if (bank_window_enable && req.direct_addr >= ERM_WIN_LO
					&& req.direct_addr <= ERM_WIN_HI)
				begin
					route.onchip_addr = {bank_window_select, req.direct_addr[5:0]};
					// Banks 0 to 3 land in scratchpad, 4 to 15 in expanded RAM.
					if (route.onchip_addr < ERM_XRAM_BASE)
					begin
						route.target = ERM_TGT_SCRATCH;
					end
					else
					begin
						route.target = ERM_TGT_XRAM;
						route.onchip_addr = route.onchip_addr - ERM_XRAM_BASE;
					end
				end
			end
		endcase
	end

endmodule // erm_decode

/* rtl/erm_mapper.sv */
// Expanded RAM address mapper: configuration registers, data pointer and routing.
// Function
// - Enabled expanded RAM serves in-range external moves
// - Pointer moves beyond 768 bytes go off-chip
// - Enable cleared sends every external move off-chip
// - Expanded RAM enable resets to one
// - Indirect address is page bits plus register
// - Pages 0..2 map to 256-byte expanded pages
// - Window 40..7F prefixed with bank select
// - Scratchpad at zero, expanded RAM above
// - Bank window active only with enable
// - Sixteen 64-byte banks, 0..3 scratchpad
// - Data pointer byte-writable and 16-bit loadable
// - Enable bit 1 of config, reset 02
`timescale 1ns/1ps
module erm_mapper
	import erm_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register write port from the core
	input wire erm_sfr_s sfr,
	// Register read port
	input wire logic [7:0] sfr_raddr,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Access request from the core
	input wire erm_req_s req,
	// Steered access, registered
	output erm_route_s route_q,
	output logic [15:0] data_pointer16
);

	// ****************************************
	// Write decode
	// ****************************************
	logic wr_ptr_lo;
	logic wr_ptr_hi;
	logic wr_page;
	logic wr_bank;
	logic wr_syscfg;

	// A write strobe only counts for the one register that its address names.
	function automatic logic is_wr(input erm_sfr_s s, input logic [7:0] a);
		is_wr = s.wr_en && (s.addr == a);
	endfunction

	assign wr_ptr_lo = is_wr(sfr, ERM_PTR_LO_ADDR);
	assign wr_ptr_hi = is_wr(sfr, ERM_PTR_HI_ADDR);
	assign wr_page = is_wr(sfr, ERM_PAGE_ADDR);
	assign wr_bank = is_wr(sfr, ERM_BANK_ADDR);
	assign wr_syscfg = is_wr(sfr, ERM_SYSCFG_ADDR);

	// ****************************************
	// Data pointer
	// ****************************************
	logic [7:0] ptr_lo_reg;
	logic [7:0] ptr_lo_next;
	logic [7:0] ptr_hi_reg;
	logic [7:0] ptr_hi_next;

	always_comb
	begin
		ptr_lo_next = ptr_lo_reg;
		ptr_hi_next = ptr_hi_reg;
		// A 16-bit load takes priority over a byte write in the same cycle.
		if (sfr.ptr_load)
		begin
			ptr_lo_next = sfr.ptr_value[7:0];
			ptr_hi_next = sfr.ptr_value[15:8];
		end
		else
		begin
			if (wr_ptr_lo)
			begin
				ptr_lo_next = sfr.wdata;
			end
			if (wr_ptr_hi)
			begin
				ptr_hi_next = sfr.wdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ptr_lo_reg <= ERM_PTR_LO_RST;
			ptr_hi_reg <= ERM_PTR_HI_RST;
		end
		else
		begin
			ptr_lo_reg <= ptr_lo_next;
			ptr_hi_reg <= ptr_hi_next;
		end
	end

	// The pointer leaves the block as one word, high byte first.
	assign data_pointer16 = {ptr_hi_reg, ptr_lo_reg};

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] page_reg;
	logic [7:0] page_next;
	logic [7:0] bank_reg;
	logic [7:0] bank_next;
	logic [7:0] syscfg_reg;
	logic [7:0] syscfg_next;

	// Reserved bits are dropped on write so that they always read back as zero.
	always_comb
	begin
		page_next = page_reg;
		bank_next = bank_reg;
		syscfg_next = syscfg_reg;
		if (wr_page)
		begin
			page_next = sfr.wdata & ERM_PAGE_MASK;
		end
		if (wr_bank)
		begin
			bank_next = sfr.wdata & ERM_BANK_MASK;
		end
		if (wr_syscfg)
		begin
			syscfg_next = sfr.wdata & ERM_SYSCFG_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			page_reg <= ERM_PAGE_RST;
			bank_reg <= ERM_BANK_RST;
			syscfg_reg <= ERM_SYSCFG_RST;
		end
		else
		begin
			page_reg <= page_next;
			bank_reg <= bank_next;
			syscfg_reg <= syscfg_next;
		end
	end

	// ****************************************
	// Register read-back
	// ****************************************
	always_comb
	begin
		sfr_hit = 1'b1;
		unique case (sfr_raddr)
			ERM_PTR_LO_ADDR:
			begin
				sfr_rdata = ptr_lo_reg;
			end
			ERM_PTR_HI_ADDR:
			begin
				sfr_rdata = ptr_hi_reg;
			end
			ERM_PAGE_ADDR:
			begin
				sfr_rdata = page_reg;
			end
			ERM_BANK_ADDR:
			begin
				sfr_rdata = bank_reg;
			end
			ERM_SYSCFG_ADDR:
			begin
				sfr_rdata = syscfg_reg;
			end
			default:
			begin
				sfr_hit = 1'b0;
				sfr_rdata = 8'h00;
			end
		endcase
	end

	// ****************************************
	// Routing
	// ****************************************
	// The decode uses settled register values, so a write takes effect on the next access.
	erm_route_s route_c;
	erm_route_s route_reg;
	erm_route_s route_next;

	erm_decode u_decode (
		.req(req),
		.data_pointer16(data_pointer16),
		.onchip_xram_enable(syscfg_reg[ERM_XRAM_EN_BIT]),
		.xram_page_sel(page_reg[1:0]),
		.bank_window_enable(bank_reg[ERM_BANK_EN_BIT]),
		.bank_window_select(bank_reg[3:0]),
		.route(route_c)
	);

	always_comb
	begin
		route_next = route_c;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			route_reg <= '0;
		end
		else
		begin
			route_reg <= route_next;
		end
	end

	// One register stage costs a cycle but keeps decode glitches away from the memories.
	assign route_q = route_reg;

endmodule // erm_mapper

/* test/erm_mapper_properties.sv */
// Port checker for the expanded RAM mapper, bound to its top module.
`timescale 1ns/1ps
module erm_props
	import erm_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register ports
	input wire erm_sfr_s sfr,
	input wire logic [7:0] sfr_raddr,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	// Access ports
	input wire erm_req_s req,
	input wire erm_route_s route_q,
	input wire logic [15:0] data_pointer16
);
	logic [7:0] st_reg;
	logic [7:0] st_next;
	logic [9:0] lg;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Shadow of enable, page and bank fields; a write steers every cycle from the next one on.
	always_comb
	begin
		st_next = st_reg;
		if (sfr.wr_en && sfr.addr == ERM_SYSCFG_ADDR) st_next[7] = sfr.wdata[1];
		if (sfr.wr_en && sfr.addr == ERM_PAGE_ADDR) st_next[6:5] = sfr.wdata[1:0];
		if (sfr.wr_en && sfr.addr == ERM_BANK_ADDR) st_next[4:0] = {sfr.wdata[7], sfr.wdata[3:0]};
		lg = {st_reg[3:0], req.direct_addr[5:0]} - ((st_reg[3:2] != 2'h0) ? 10'h100 : 10'h0);
	end
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b) st_reg <= 8'h81;
		else st_reg <= st_next;
	sequence s_ptr_in;
		req.kind == ERM_ACC_XMOVE_PTR && st_reg[7] && data_pointer16 <= 16'h02ff;
	endsequence
	sequence s_win;
		req.kind == ERM_ACC_DIRECT && st_reg[4] && req.direct_addr[7:6] == 2'h1;
	endsequence
	a_ptr_onchip: assert property (s_ptr_in |=>
		route_q.target == ERM_TGT_XRAM && route_q.onchip_addr == $past(data_pointer16[9:0]))
		else $error("pointer move missed expanded RAM");
	a_ptr_offchip: assert property (req.kind == ERM_ACC_XMOVE_PTR &&
		!(st_reg[7] && data_pointer16 <= 16'h02ff) |=> route_q.target == ERM_TGT_OFFCHIP
		&& route_q.offchip_addr == $past(data_pointer16)) else $error("pointer move not off chip");
	a_idx_page: assert property (req.kind == ERM_ACC_XMOVE_IDX && st_reg[7] &&
		st_reg[6:5] != 2'h3 |=> route_q.target == ERM_TGT_XRAM && route_q.onchip_addr ==
		{$past(st_reg[6:5]), $past(req.indirect_index_reg)}) else $error("paged move wrong");
	a_idx_offchip: assert property (req.kind == ERM_ACC_XMOVE_IDX &&
		!(st_reg[7] && st_reg[6:5] != 2'h3) |=> route_q.target == ERM_TGT_OFFCHIP &&
		route_q.offchip_addr == {$past(req.port2_upper_address), $past(req.indirect_index_reg)})
		else $error("indirect move not off chip");
	a_win_addr: assert property (s_win |=> route_q.onchip_addr == $past(lg))
		else $error("window address wrong");
	a_win_target: assert property (s_win |=> route_q.target ==
		(($past(st_reg[3:2]) == 2'h0) ? ERM_TGT_SCRATCH : ERM_TGT_XRAM)) else $error("bank target wrong");
	a_win_off: assert property (req.kind == ERM_ACC_DIRECT && !st_reg[4] |=>
		route_q.target == ERM_TGT_CORE) else $error("window mapped while off");
	a_dp_load: assert property (sfr.ptr_load |=> data_pointer16 == $past(sfr.ptr_value))
		else $error("pointer load lost");
endmodule // erm_props

bind erm_mapper erm_props erm_props_i (.mclk, .rst_b, .sfr, .sfr_raddr, .sfr_rdata, .sfr_hit,
	.req, .route_q, .data_pointer16);

/* test/erm_core_model.sv */
// Core-side model that presents one data access to the mapper per cycle.
`timescale 1ns/1ps
module erm_core_model
	import erm_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Access asked for by the bench
	input wire erm_req_s nxt,
	// Access towards the mapper
	output erm_req_s req
);
	// The core launches each access just after an edge so the mapper never races it.
	initial req = '0;
	always @(posedge mclk) req <= #1 nxt;
endmodule // erm_core_model

/* test/tb_top.sv */
// Self-checking bench for the expanded RAM mapper.
`timescale 1ns/1ps
module tb_top
	import erm_pkg::*;
;
	logic mclk = 0;
	logic rst_b = 0;
	erm_sfr_s sfr = '0;
	logic [7:0] sfr_raddr = 8'h00;
	logic [7:0] sfr_rdata;
	logic sfr_hit;
	erm_req_s req;
	erm_req_s nxt = '0;
	erm_route_s route_q;
	logic [15:0] dp16;
	logic [15:0] dp = 16'h0000;
	logic xen = 1;
	logic [1:0] pg = 2'h0;
	logic [7:0] bk = 8'h01;
	logic [7:0] ra [6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hbf};
	logic [8:0] rv [6] = '{9'h100, 9'h100, 9'h000, 9'h100, 9'h101, 9'h102};
	int bad_count = 0;
	int check_count = 0;
	always #2.5 mclk = ~mclk;
	erm_core_model erm_core_model_i (.mclk, .nxt, .req);
	erm_mapper erm_mapper_i (.mclk, .rst_b, .sfr, .sfr_raddr, .sfr_rdata, .sfr_hit, .req, .route_q,
		.data_pointer16(dp16));
	task chk(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_route(input logic [17:0] exp);
		chk({route_q.target, (route_q.target == ERM_TGT_OFFCHIP) ? route_q.offchip_addr :
			{6'h0, route_q.onchip_addr}}, exp);
	endtask
	function logic [7:0] mask(input logic [7:0] a);
		case (a)
			8'h82, 8'h83: mask = 8'hff;
			8'h85: mask = 8'h03;
			8'h86: mask = 8'h8f;
			8'hbf: mask = 8'h93;
			default: mask = 8'h00;
		endcase
	endfunction
	function logic [17:0] want(input erm_req_s r);
		logic [9:0] l;
		l = {bk[3:0], r.direct_addr[5:0]};
		if (r.kind == ERM_ACC_NONE)
			want = {ERM_TGT_CORE, 16'h0000};
		else if (r.kind == ERM_ACC_XMOVE_PTR)
			want = (xen && dp < 16'h0300) ? {ERM_TGT_XRAM, 6'h0, dp[9:0]} : {ERM_TGT_OFFCHIP, dp};
		else if (r.kind == ERM_ACC_XMOVE_IDX)
			want = (xen && pg != 2'h3) ? {ERM_TGT_XRAM, 6'h0, pg, r.indirect_index_reg} :
				{ERM_TGT_OFFCHIP, r.port2_upper_address, r.indirect_index_reg};
		else if (r.kind == ERM_ACC_DIRECT && bk[7] && r.direct_addr[7:6] == 2'h1)
			want = (l < 10'h100) ? {ERM_TGT_SCRATCH, 6'h0, l} : {ERM_TGT_XRAM, 6'h0, l - 10'h100};
		else
			want = {ERM_TGT_CORE, 8'h0, r.direct_addr};
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] e;
		e = d & mask(a);
		if (sfr.ptr_load && a == 8'h82) e = sfr.ptr_value[7:0];
		if (sfr.ptr_load && a == 8'h83) e = sfr.ptr_value[15:8];
		sfr_raddr = a;
		sfr.addr = a;
		sfr.wdata = d;
		sfr.wr_en = 1;
		@(posedge mclk) #1 sfr.wr_en = 0;
		if (a == 8'h82) dp[7:0] = d;
		if (a == 8'h83) dp[15:8] = d;
		if (a == 8'h85) pg = d[1:0];
		if (a == 8'h86) bk = d & 8'h8f;
		if (a == 8'hbf) xen = d[1];
		chk({mask(a) != 8'h00, sfr_hit, sfr_rdata}, {mask(a) != 8'h00, mask(a) != 8'h00, e});
	endtask
	task access(input erm_req_s r);
		logic [17:0] e;
		e = want(r);
		nxt = r;
		@(posedge mclk) #1 nxt = '0;
		@(posedge mclk) #1 chk_route(e);
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#50000;
		bad_count++;
		conclude();
	end
	initial
	begin
		erm_req_s r;
		logic [15:0] v;
		void'($urandom(52622));
		repeat (12) @(posedge mclk);
		#1 rst_b = 1;
		foreach (ra[i])
		begin
			sfr_raddr = ra[i];
			@(posedge mclk) #1 chk({sfr_hit, sfr_rdata}, rv[i]);
		end
		$display("reset values done");
		wr(8'h86, 8'h88);
		access('{ERM_ACC_DIRECT, 8'h00, 8'h41, 8'h00});
		$display("bank window example done");
		repeat (300)
		begin
			if ($urandom % 4 == 0)
			begin
				v = ($urandom % 2) ? 16'h02ff + 16'($urandom % 2) : 16'($urandom % 1536);
				sfr.ptr_load = 1;
				sfr.ptr_value = v;
				wr(8'h82, 8'($urandom));
				sfr.ptr_load = 0;
				dp = v;
				chk({2'b00, dp16}, {2'b00, v});
			end
			else
				wr(ra[$urandom % 6], 8'($urandom));
			r = erm_req_s'($urandom);
			if ($urandom % 2) r.direct_addr[7:6] = 2'h1;
			access(r);
		end
		$display("random traffic done");
		conclude();
	end
endmodule // tb_top
